/* File: thd_regs.sv */
// Host register group: output/mode control, debug selectors, debug window, touch state.
// Assumes the serial slave delivers at most one byte access per cycle on regReq.
//
// Contract
// - Mode bits 7:4 drive host outputs three..zero.
// - Mode field codes zero to four select mode.
// - Start button field picks first packed button.
// - Selector code fixes data type and size.
// - Two-byte values packed high byte first.
// - Twenty-five window bytes at 0x07..0x1F.
// - Code four packs all of one button.
// - Two read-only registers show touch states.
// - Status, outputs and selectors reset to zero.
`default_nettype none
module thd_regs
   import thd_pkg::*;
(
   input  wire logic                            ref_clk,
   input  wire logic                            rst,
   input  wire thd_req_t                        regReq,
   output logic [7:0]                           regRdData,
   input  wire thd_meas_t [THD_NUM_BUTTONS-1:0] buttonMeas,
   input  wire logic [THD_NUM_BUTTONS-1:0]      buttonEnable,
   input  wire logic [THD_NUM_BUTTONS-1:0]      touchState,
   output logic [3:0]                           hostOut,
   output logic [2:0]                           deviceMode
);
   //==========================================================
   // State
   logic [3:0]                      hostOut_ff;
   logic [2:0]                      mode_ff;
   logic [4:0]                      start_ff;
   logic [2:0]                      select_ff;
   logic [THD_NUM_BUTTONS-1:0]      touch_ff;
   logic [7:0]                      rdData_ff;
   logic [7:0]                      window_ff [THD_WIN_BYTES];
   thd_state_t                      state_ff;
   logic [3:0]                      btn_ff;
   logic [2:0]                      part_ff;
   logic [4:0]                      wrPtr_ff;

   //==========================================================
   // Decode
   wire logic       wrMode    = regReq.wrEn && regReq.addr == THD_OFS_MODE;
   wire logic       wrStart   = regReq.wrEn && regReq.addr == THD_OFS_START;
   wire logic       wrSelect  = regReq.wrEn && regReq.addr == THD_OFS_SELECT;
   wire logic       selWrite  = wrStart || wrSelect;
   wire logic       modeOk    = regReq.data[2:0] <= THD_MODE_DEBUG;
   wire logic       inWindow  = regReq.addr >= THD_OFS_WIN_FIRST && regReq.addr <= THD_OFS_WIN_LAST;
   wire logic [4:0] winIdx    = 5'(regReq.addr - THD_OFS_WIN_FIRST);

   //==========================================================
   // Packing engine
   wire thd_meas_t  curMeas   = buttonMeas[btn_ff];
   wire logic       btnValid  = btn_ff <= THD_LAST_BUTTON;
   wire logic       btnOn     = btnValid && buttonEnable[btn_ff];
   logic [3:0]      perButton;
   logic [7:0]      curByte;

   always_comb
   begin
      case (select_ff)
         THD_SEL_CP:    perButton = 4'h1;
         THD_SEL_RAW:   perButton = 4'h2;
         THD_SEL_DIFF:  perButton = 4'h2;
         THD_SEL_RAWBL: perButton = 4'h4;
         THD_SEL_ALL:   perButton = 4'h8;
         default:       perButton = 4'h0;
      endcase
   end

   // High byte always lands first, low byte in the next slot
   always_comb
   begin
      curByte = THD_RST_BYTE;
      case (select_ff)
         THD_SEL_CP:    curByte = curMeas.parasiticCap;
         THD_SEL_RAW:   curByte = part_ff[0] ? curMeas.rawCount[7:0] : curMeas.rawCount[15:8];
         THD_SEL_DIFF:  curByte = part_ff[0] ? curMeas.diffCount[7:0] : curMeas.diffCount[15:8];
         THD_SEL_RAWBL:
         begin
            case (part_ff)
               3'h0:    curByte = curMeas.rawCount[15:8];
               3'h1:    curByte = curMeas.rawCount[7:0];
               3'h2:    curByte = curMeas.baselineCount[15:8];
               default: curByte = curMeas.baselineCount[7:0];
            endcase
         end
         THD_SEL_ALL:
         begin
            case (part_ff)
               3'h0:    curByte = curMeas.rawCount[15:8];
               3'h1:    curByte = curMeas.rawCount[7:0];
               3'h2:    curByte = curMeas.baselineCount[15:8];
               3'h3:    curByte = curMeas.baselineCount[7:0];
               3'h4:    curByte = curMeas.diffCount[15:8];
               3'h5:    curByte = curMeas.diffCount[7:0];
               3'h6:    curByte = curMeas.parasiticCap;
               default: curByte = curMeas.signalNoiseRatio;
            endcase
         end
         default:       curByte = THD_RST_BYTE;
      endcase
   end

   // Code four stops once the start button is passed
   wire logic pastSingle = select_ff == THD_SEL_ALL && btn_ff != 4'(start_ff);
   wire logic fillDone   = !btnValid || wrPtr_ff == THD_WIN_LEN || perButton == 4'h0 || pastSingle;
   wire logic fillByte   = state_ff == THD_FILL && !fillDone && btnOn && !selWrite;
   wire logic lastPart   = {1'b0, part_ff} == 4'(perButton - 4'h1);
   wire logic nxt_advBtn = state_ff == THD_FILL && !fillDone && (!btnOn || lastPart);
   thd_state_t nxt_state;

   always_comb
   begin
      case (state_ff)
         THD_IDLE: nxt_state = (mode_ff == THD_MODE_DEBUG && !selWrite) ? THD_FILL : THD_IDLE;
         THD_FILL: nxt_state = (fillDone || selWrite) ? THD_IDLE : THD_FILL;
         default:  nxt_state = THD_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         state_ff <= THD_IDLE;
         btn_ff   <= 4'h0;
         part_ff  <= 3'h0;
         wrPtr_ff <= 5'h00;
      end
      else
      begin
         state_ff <= nxt_state;
         if (state_ff == THD_IDLE)
         begin
            btn_ff   <= start_ff[3:0] | {4{start_ff[4]}};
            part_ff  <= 3'h0;
            wrPtr_ff <= 5'h00;
         end
         else
         begin
            btn_ff   <= nxt_advBtn ? btn_ff + 4'h1 : btn_ff;
            part_ff  <= nxt_advBtn ? 3'h0 : (fillByte ? part_ff + 3'h1 : part_ff);
            wrPtr_ff <= fillByte ? wrPtr_ff + 5'h01 : wrPtr_ff;
         end
      end
   end

   // New selection clears stale window bytes; a continuous refresh follows
   always_ff @(posedge ref_clk)
   begin
      for (int i = 0; i < THD_WIN_BYTES; i++)
      begin
         if (rst || selWrite)
            window_ff[i] <= THD_RST_BYTE;
         else if (fillByte && wrPtr_ff == 5'(i))
            window_ff[i] <= curByte;
      end
   end

   //==========================================================
   // Control registers
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         hostOut_ff <= THD_RST_HOSTOUT;
         mode_ff    <= THD_RST_MODE;
         start_ff   <= THD_RST_START;
         select_ff  <= THD_RST_SELECT;
         touch_ff   <= '0;
      end
      else
      begin
         // Invalid mode code drops the whole byte, outputs included
         if (wrMode && modeOk)
            hostOut_ff <= regReq.data[7:THD_HOSTOUT_LSB];
         if (wrMode && modeOk)
            mode_ff <= regReq.data[2:0];
         if (wrStart)
            start_ff <= regReq.data[4:0];
         if (wrSelect)
            select_ff <= regReq.data[2:0];
         touch_ff <= touchState;
      end
   end

   //==========================================================
   // Read path
   logic [7:0] nxt_rdData;

   always_comb
   begin
      if (inWindow)
         nxt_rdData = window_ff[winIdx];
      else
      begin
         case (regReq.addr)
            THD_OFS_MODE:     nxt_rdData = {hostOut_ff, 1'b0, mode_ff};
            THD_OFS_START:    nxt_rdData = {3'h0, start_ff};
            THD_OFS_SELECT:   nxt_rdData = {5'h00, select_ff};
            THD_OFS_STATE_LO: nxt_rdData = touch_ff[7:0];
            THD_OFS_STATE_HI: nxt_rdData = {6'h00, touch_ff[9:8]};
            default:          nxt_rdData = THD_RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         rdData_ff <= THD_RST_BYTE;
      else if (regReq.rdEn)
         rdData_ff <= nxt_rdData;
   end

   assign regRdData  = rdData_ff;
   assign hostOut    = hostOut_ff;
   assign deviceMode = mode_ff;

   //==========================================================
   // Checks
   sequence wrMode_s;
      wrMode;
   endsequence
   sequence rawHigh_s;
      fillByte && select_ff == THD_SEL_RAW && part_ff == 3'h0;
   endsequence

   host_out_a: assert property (@(posedge ref_clk) disable iff (rst)
      wrMode_s ##0 modeOk |=> hostOut == $past(regReq.data[7:4]))
      else $error("host outputs not taken from write");
   mode_set_a: assert property (@(posedge ref_clk) disable iff (rst)
      wrMode_s ##0 modeOk |=> deviceMode == $past(regReq.data[2:0]))
      else $error("valid mode not taken");
   mode_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      wrMode && !modeOk |=> $stable(deviceMode) && $stable(hostOut))
      else $error("invalid mode altered mode field");
   reset_zero_a: assert property (@(posedge ref_clk)
      rst |=> hostOut == 4'h0 && start_ff == 5'h00 && select_ff == 3'h0 && touch_ff == '0
         && deviceMode == THD_RST_MODE)
      else $error("reset values not zero");
   touch_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
      regReq.rdEn && regReq.addr == THD_OFS_STATE_HI ##1 !$past(rst, 2)
      |-> regRdData == {6'h00, $past(touch_ff[9:8])})
      else $error("high touch register wrong");
   msb_first_a: assert property (@(posedge ref_clk) disable iff (rst || selWrite)
      rawHigh_s |=> window_ff[$past(wrPtr_ff)] == $past(curMeas.rawCount[15:8]))
      else $error("raw high byte not first");
   window_bound_a: assert property (@(posedge ref_clk) disable iff (rst)
      fillByte |-> wrPtr_ff < THD_WIN_LEN)
      else $error("write past window");
   start_btn_a: assert property (@(posedge ref_clk) disable iff (rst)
      state_ff == THD_IDLE ##1 state_ff == THD_FILL |-> btn_ff == ($past(start_ff[3:0]) | {4{$past(start_ff[4])}}))
      else $error("fill did not begin at start button");
   single_btn_a: assert property (@(posedge ref_clk) disable iff (rst)
      fillByte && select_ff == THD_SEL_ALL |-> btn_ff == 4'(start_ff) && wrPtr_ff < 5'h08)
      else $error("code four packed other buttons");
   skip_off_a: assert property (@(posedge ref_clk) disable iff (rst)
      fillByte |-> buttonEnable[btn_ff])
      else $error("disabled button packed");
endmodule
`default_nettype wire

/* File: thd_pkg.sv */
// Constants and carrier types for the touch host debug register group.
// Assumes one 25 MHz clock and a byte register port fed by the serial slave.
`default_nettype none
package thd_pkg;
   //==========================================================
   // Register offsets
   localparam logic [7:0] THD_OFS_MODE      = 8'h00;
   localparam logic [7:0] THD_OFS_START     = 8'h01;
   localparam logic [7:0] THD_OFS_SELECT    = 8'h02;
   localparam logic [7:0] THD_OFS_WIN_FIRST = 8'h07;
   localparam logic [7:0] THD_OFS_WIN_LAST  = 8'h1F;
   localparam logic [7:0] THD_OFS_STATE_LO  = 8'h20;
   localparam logic [7:0] THD_OFS_STATE_HI  = 8'h21;
   //==========================================================
   // Field positions and sizes
   localparam int         THD_HOSTOUT_LSB   = 4;
   localparam int         THD_NUM_BUTTONS   = 10;
   localparam int         THD_WIN_BYTES     = 25;
   localparam logic [3:0] THD_LAST_BUTTON   = 4'h9;
   localparam logic [4:0] THD_WIN_LEN       = 5'h19;
   //==========================================================
   // Reset values
   localparam logic [3:0] THD_RST_HOSTOUT   = 4'h0;
   // Powers up in debug data mode
   localparam logic [2:0] THD_RST_MODE      = 3'h4;
   localparam logic [4:0] THD_RST_START     = 5'h00;
   localparam logic [2:0] THD_RST_SELECT    = 3'h0;
   localparam logic [7:0] THD_RST_BYTE      = 8'h00;
   //==========================================================
   // Modes and data selections
   typedef enum logic [2:0] {
      THD_MODE_NORMAL = 3'h0,
      THD_MODE_LEDCFG = 3'h1,
      THD_MODE_DEVCFG = 3'h2,
      THD_MODE_TEST   = 3'h3,
      THD_MODE_DEBUG  = 3'h4
   } thd_mode_t;
   typedef enum logic [2:0] {
      THD_SEL_CP    = 3'h0,
      THD_SEL_RAW   = 3'h1,
      THD_SEL_DIFF  = 3'h2,
      THD_SEL_RAWBL = 3'h3,
      THD_SEL_ALL   = 3'h4
   } thd_sel_t;
   typedef enum logic [1:0] {
      THD_IDLE = 2'b01,
      THD_FILL = 2'b10
   } thd_state_t;
   //==========================================================
   // Carriers
   typedef struct packed {
      logic [15:0] rawCount;
      logic [15:0] baselineCount;
      logic [15:0] diffCount;
      logic [7:0]  parasiticCap;
      logic [7:0]  signalNoiseRatio;
   } thd_meas_t;
   typedef struct packed {
      logic       wrEn;
      logic       rdEn;
      logic [7:0] addr;
      logic [7:0] data;
   } thd_req_t;
endpackage
`default_nettype wire

/* File: thd_host_model.sv */
// Host side model: issues byte register accesses on the request port.
// Assumes every access is launched 1 ns after a rising edge of ref_clk.
`default_nettype none
module thd_host_model
   import thd_pkg::*;
(
   input  wire logic    ref_clk,
   output var thd_req_t regReq
);
   timeunit 1ns;
   timeprecision 1ps;
   initial regReq = '0;
   //==========================================================
   // Access tasks
   // Back to back calls keep the port busy one access per edge
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      regReq = '{wrEn: w, rdEn: !w, addr: a, data: d};
   endtask
   // Released address and data toggle so stale values never match
   task automatic idle();
      @(posedge ref_clk);
      #1;
      regReq = '{1'b0, 1'b0, ~regReq.addr, ~regReq.data};
   endtask
endmodule
`default_nettype wire

/* File: tb_touch_host_debug_regs.sv */
// Self-checking bench for the touch host debug register group.
// Assumes thd_pkg, thd_regs and thd_host_model are compiled first.
`default_nettype none
module tb_touch_host_debug_regs
   import thd_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic            ref_clk = 1'b0;
   logic            rst = 1'b1;
   thd_req_t        regReq;
   logic [7:0]      regRdData;
   thd_meas_t [9:0] meas = '0;
   logic [9:0]      en = '1;
   logic [9:0]      ts = '0;
   logic [3:0]      hostOut;
   logic [2:0]      deviceMode;
   logic [7:0]      expQ[$];
   logic [7:0]      win[25];
   logic            rdPend = 1'b0;
   logic [31:0]     seed = 32'h3E19;
   logic [31:0]     r;
   logic [7:0]      d;
   logic [2:0]      m;
   logic [3:0]      h;
   int              n;
   int              error_cnt = 0;
   int              compares = 0;
   logic [7:0]      ra[8] = '{8'h00, 8'h01, 8'h02, 8'h07, 8'h1F, 8'h20, 8'h21, 8'h30};
   logic [4:0]      st[9] = '{5'h00, 5'h04, 5'h03, 5'h00, 5'h06, 5'h02, 5'h05, 5'h00, 5'h0C};
   logic [2:0]      sl[9] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h5, 3'h1};
   always #20 ref_clk = ~ref_clk;
   thd_host_model i_thd_host_model (.ref_clk(ref_clk), .regReq(regReq));
   thd_regs i_thd_regs (.ref_clk(ref_clk), .rst(rst), .regReq(regReq), .regRdData(regRdData),
      .buttonMeas(meas), .buttonEnable(en), .touchState(ts), .hostOut(hostOut), .deviceMode(deviceMode));
   //==========================================================
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      i_thd_host_model.acc(1'b1, a, v);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      i_thd_host_model.acc(1'b0, a, ~e);
      expQ.push_back(e);
   endtask
   // Read data stands one edge after the edge that took the read
   always @(posedge ref_clk)
   begin
      if (rdPend)
         chk(regRdData, expQ.pop_front());
      rdPend <= regReq.rdEn;
   end
   task automatic put(input logic [7:0] b);
      if (n < THD_WIN_BYTES)
         win[n] = b;
      n++;
   endtask
   task automatic put16(input logic [15:0] v);
      put(v[15:8]);
      put(v[7:0]);
   endtask
   task automatic pack(input logic [4:0] s, input logic [2:0] p);
      foreach (win[i]) win[i] = 8'h00;
      n = 0;
      for (int b = s; b < 10 && !(p == 3'h4 && b > s); b++)
         if (en[b])
            case (p)
               3'h0: put(meas[b].parasiticCap);
               3'h1: put16(meas[b].rawCount);
               3'h2: put16(meas[b].diffCount);
               3'h3:
               begin
                  put16(meas[b].rawCount);
                  put16(meas[b].baselineCount);
               end
               3'h4:
               begin
                  put16(meas[b].rawCount);
                  put16(meas[b].baselineCount);
                  put16(meas[b].diffCount);
                  put(meas[b].parasiticCap);
                  put(meas[b].signalNoiseRatio);
               end
               default: ;
            endcase
   endtask
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      #200000;
      error_cnt++;
      conclude();
   end
   //==========================================================
   // Tests
   initial
   begin
      repeat (12) @(posedge ref_clk);
      #1 rst = 1'b0;
      chk({hostOut, 1'b0, deviceMode}, {THD_RST_HOSTOUT, 1'b0, THD_RST_MODE});
      foreach (ra[i]) rd(ra[i], ra[i] == THD_OFS_MODE ? {THD_RST_HOSTOUT, 1'b0, THD_RST_MODE} : 8'h00);
      i_thd_host_model.idle();
      $display("Test reset values done");
      m = THD_RST_MODE;
      h = THD_RST_HOSTOUT;
      for (int c = 0; c < 8; c++)
      begin
         r = rnd();
         d = {r[3:0], 1'b0, c[2:0]};
         wr(THD_OFS_MODE, d);
         // Codes five to seven leave outputs and mode as they were
         if (c < 5)
         begin
            m = c[2:0];
            h = d[7:4];
         end
         i_thd_host_model.idle();
         chk({hostOut, 1'b0, deviceMode}, {h, 1'b0, m});
         rd(THD_OFS_MODE, {h, 1'b0, m});
      end
      i_thd_host_model.idle();
      $display("Test mode and outputs done");
      r = rnd();
      ts = r[9:0];
      repeat (2) @(posedge ref_clk);
      rd(THD_OFS_STATE_LO, ts[7:0]);
      rd(THD_OFS_STATE_HI, {6'h00, ts[9:8]});
      i_thd_host_model.idle();
      $display("Test touch state done");
      // Split reads of start 0 then 6 are the host's partial read
      for (int k = 0; k < 9; k++)
      begin
         r = rnd();
         en = (r[9:0] | 10'h004) & 10'h3DF;
         foreach (meas[b]) meas[b] = {rnd(), rnd()};
         wr(THD_OFS_START, {3'h0, st[k]});
         wr(THD_OFS_SELECT, {5'h00, sl[k]});
         i_thd_host_model.idle();
         repeat (50) @(posedge ref_clk);
         pack(st[k], sl[k]);
         for (int i = 0; i < 25; i++)
            rd(THD_OFS_WIN_FIRST + i[7:0], win[i]);
         rd(THD_OFS_START, {3'h0, st[k]});
         rd(THD_OFS_SELECT, {5'h00, sl[k]});
         i_thd_host_model.idle();
      end
      $display("Test debug window done");
      repeat (3) @(posedge ref_clk);
      conclude();
   end
endmodule
`default_nettype wire
